// [logic/plh_pkg.sv]
package plh_pkg;

  // APB register byte addresses.
  localparam logic [7:0] OFS_PFD_CTRL = 8'h5C;
  localparam logic [7:0] OFS_LOCK_CTRL = 8'h60;
  localparam logic [7:0] OFS_SYNC_CTRL = 8'h64;
  localparam logic [7:0] OFS_LDPIN_CTRL = 8'h68;
  localparam logic [7:0] OFS_MON_CTRL = 8'h6C;
  localparam logic [7:0] OFS_HOLD_CTRL = 8'h74;
  localparam logic [7:0] OFS_STATUS = 8'h80;

  // Field positions.
  localparam int ABP_LSB = 0;
  localparam int STAT_SEL_LSB = 2;
  localparam int WIN_RANGE_BIT = 4;
  localparam int LDCNT_LSB = 5;
  localparam int SYNC_RST_LSB = 6;
  localparam int RDLY_LSB = 0;
  localparam int NDLY_LSB = 3;
  localparam int HOLD_EN0_BIT = 0;
  localparam int HOLD_EXT_BIT = 1;
  localparam int HOLD_EN2_BIT = 2;
  localparam int LDCMP_EN_BIT = 3;

  // Reset values.
  localparam logic [7:0] RST_PFD_CTRL = 8'h00;
  localparam logic [7:0] RST_LOCK_CTRL = 8'h00;
  localparam logic [7:0] RST_SYNC_CTRL = 8'h00;
  localparam logic [7:0] RST_LDPIN_CTRL = 8'h00;
  localparam logic [7:0] RST_MON_CTRL = 8'h00;
  localparam logic [7:0] RST_HOLD_CTRL = 8'h00;

  // Output mux codes shared by all three status pins.
  localparam logic [5:0] MUX_LOW = 6'h00;
  localparam logic [5:0] MUX_DLD = 6'h01;
  localparam logic [5:0] MUX_CSRC = 6'h04;
  localparam logic [5:0] MUX_CMP_HI = 6'h05;
  localparam logic [5:0] MUX_CMP_LO = 6'h06;

  // Lock counts per counter code, and lock-pin charge time.
  localparam logic [7:0] LDCNT_0 = 8'h05;
  localparam logic [7:0] LDCNT_1 = 8'h10;
  localparam logic [7:0] LDCNT_2 = 8'h40;
  localparam logic [7:0] LDCNT_3 = 8'hFF;
  localparam int CHARGE_NS = 1000;
  localparam int CLK_NS = 5;
  localparam int CHARGE_CYC = (CHARGE_NS + CLK_NS - 1) / CLK_NS;

  // Delay stage span.
  localparam int DLY_SPAN_PS = 1000;

  // Edge measurement result from the phase detector side.
  typedef struct packed {
    logic valid;
    logic [7:0] diff;
  } plh_edge_type;

  // Counter reset strobes.
  typedef struct packed {
    logic r_rst;
    logic a_rst;
    logic b_rst;
  } plh_ctr_rst_type;

endpackage

// [logic/plh_top.sv]
// Chosen here: register access over APB and the register addresses.
module plh_top
  import plh_pkg::*;
#(
  parameter int DIFF_W = 8
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Detector side: measured edge difference and reference edge strobe.
  input wire plh_edge_type pfd_edge,
  input wire logic ref_edge,
  // Resync pin, active low.
  input wire logic resync_n,
  // Lock-pin comparator level.
  input wire logic ldpin_cmp,
  // Divider controls.
  output logic [2:0] r_delay_sel,
  output logic [2:0] n_delay_sel,
  output plh_ctr_rst_type ctr_rst,
  // Charge pump and status pins.
  output logic pump_hiz,
  output logic lock_detect_pin,
  output logic ldpin_src_on,
  output logic status_pin,
  output logic reference_monitor_pin
);

  // Configuration registers.
  logic [7:0] pfd_ctrl;
  logic [7:0] lock_ctrl;
  logic [7:0] sync_ctrl;
  logic [7:0] ldpin_ctrl;
  logic [7:0] mon_ctrl;
  logic [7:0] hold_ctrl;

  // Lock state.
  logic digital_lock_indicator;
  logic [7:0] lock_cnt;
  logic [7:0] need_cnt;
  logic [DIFF_W-1:0] lock_thr;
  logic [DIFF_W-1:0] unlock_thr;
  logic [15:0] charge_cnt;
  logic cmp_level;
  logic manual_hold;
  logic auto_hold;
  logic hold_enabled;

  // Resync synchroniser.
  logic rs_m;
  logic rs_s;
  logic rs_d;
  logic rs_fall;
  logic rs_high;

  // Write strobe at the access phase.
  logic wr;
  assign wr = psel && penable && pwrite;

  // Zero-wait APB slave; unmapped addresses answer with an error.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pfd_ctrl <= RST_PFD_CTRL;
      lock_ctrl <= RST_LOCK_CTRL;
      sync_ctrl <= RST_SYNC_CTRL;
      ldpin_ctrl <= RST_LDPIN_CTRL;
      mon_ctrl <= RST_MON_CTRL;
      hold_ctrl <= RST_HOLD_CTRL;
    end else if (wr) begin
      unique case (paddr)
        OFS_PFD_CTRL: pfd_ctrl <= pwdata[7:0];
        OFS_LOCK_CTRL: lock_ctrl <= pwdata[7:0];
        OFS_SYNC_CTRL: sync_ctrl <= pwdata[7:0];
        OFS_LDPIN_CTRL: ldpin_ctrl <= pwdata[7:0];
        OFS_MON_CTRL: mon_ctrl <= pwdata[7:0];
        OFS_HOLD_CTRL: hold_ctrl <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // Read data, ready and error are registered in the setup cycle.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (psel && !penable) begin
        unique case (paddr)
          OFS_PFD_CTRL: prdata <= {24'h000000, pfd_ctrl};
          OFS_LOCK_CTRL: prdata <= {24'h000000, lock_ctrl};
          OFS_SYNC_CTRL: prdata <= {24'h000000, sync_ctrl};
          OFS_LDPIN_CTRL: prdata <= {24'h000000, ldpin_ctrl};
          OFS_MON_CTRL: prdata <= {24'h000000, mon_ctrl};
          OFS_HOLD_CTRL: prdata <= {24'h000000, hold_ctrl};
          OFS_STATUS: prdata <= {27'h0000000, cmp_level, auto_hold,
                                 manual_hold, pump_hiz,
                                 digital_lock_indicator};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  // Delay selects pass straight to the delay cells.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r_delay_sel <= 3'h0;
      n_delay_sel <= 3'h0;
    end else begin
      r_delay_sel <= sync_ctrl[RDLY_LSB +: 3];
      n_delay_sel <= sync_ctrl[NDLY_LSB +: 3];
    end
  end

  // Window thresholds from range bit and antibacklash width.
  always_comb begin
    lock_thr = DIFF_W'(8'h08) << pfd_ctrl[ABP_LSB +: 2];
    if (lock_ctrl[WIN_RANGE_BIT]) begin
      lock_thr = lock_thr >> 2;
    end
    unlock_thr = lock_thr << 1;
    unique case (lock_ctrl[LDCNT_LSB +: 2])
      2'h0: need_cnt = LDCNT_0;
      2'h1: need_cnt = LDCNT_1;
      2'h2: need_cnt = LDCNT_2;
      2'h3: need_cnt = LDCNT_3;
    endcase
  end

  // Lock indicator: consecutive count to lock, single miss to unlock.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      digital_lock_indicator <= 1'b0;
      lock_cnt <= 8'h00;
    end else if (pfd_edge.valid) begin
      if (!digital_lock_indicator) begin
        if (pfd_edge.diff < lock_thr) begin
          if (lock_cnt + 8'h01 >= need_cnt) begin
            digital_lock_indicator <= 1'b1;
            lock_cnt <= 8'h00;
          end else begin
            lock_cnt <= lock_cnt + 8'h01;
          end
        end else begin
          lock_cnt <= 8'h00;
        end
      end else if (pfd_edge.diff > unlock_thr) begin
        digital_lock_indicator <= 1'b0;
      end
    end
  end

  // Lock-pin charge model: any loss restarts the charge time.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      charge_cnt <= 16'h0000;
    end else if (!digital_lock_indicator) begin
      charge_cnt <= 16'h0000;
    end else if (charge_cnt < 16'(CHARGE_CYC)) begin
      charge_cnt <= charge_cnt + 16'h0001;
    end
  end

  // Comparator level, forced high when comparator disabled.
  always_comb begin
    cmp_level = hold_ctrl[LDCMP_EN_BIT] ? ldpin_cmp : 1'b1;
  end

  // Resync synchroniser and edge detect.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rs_m <= 1'b1;
      rs_s <= 1'b1;
      rs_d <= 1'b1;
    end else begin
      rs_m <= resync_n;
      rs_s <= rs_m;
      rs_d <= rs_s;
    end
  end
  assign rs_fall = rs_d && !rs_s;
  assign rs_high = rs_s;

  // Holdover needs both enable bits.
  assign hold_enabled = hold_ctrl[HOLD_EN0_BIT] && hold_ctrl[HOLD_EN2_BIT];

  // Manual and automatic holdover state.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      manual_hold <= 1'b0;
      auto_hold <= 1'b0;
    end else if (!hold_enabled) begin
      manual_hold <= 1'b0;
      auto_hold <= 1'b0;
    end else if (hold_ctrl[HOLD_EXT_BIT]) begin
      auto_hold <= 1'b0;
      if (rs_fall) begin
        manual_hold <= 1'b1;
      end else if (manual_hold && rs_high && ref_edge) begin
        manual_hold <= 1'b0;
      end
    end else begin
      manual_hold <= 1'b0;
      if (!cmp_level) begin
        auto_hold <= 1'b1;
      end else if (auto_hold && ref_edge) begin
        auto_hold <= 1'b0;
      end
    end
  end

  // Pump high impedance; set immediately on the falling edge.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pump_hiz <= 1'b0;
    end else begin
      pump_hiz <= next_hiz();
    end
  end

  function automatic logic next_hiz();
    next_hiz = (hold_enabled && hold_ctrl[HOLD_EXT_BIT] && rs_fall) ||
               (manual_hold && !(rs_high && ref_edge)) ||
               (hold_enabled && !hold_ctrl[HOLD_EXT_BIT] && !cmp_level) ||
               (auto_hold && !ref_edge);
  endfunction

  // Counter resets: pin-driven R/A/B, and B alone on holdover release.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctr_rst <= '0;
    end else begin
      ctr_rst.r_rst <= (sync_ctrl[SYNC_RST_LSB +: 2] != 2'h0) &&
                       rs_fall;
      ctr_rst.a_rst <= (sync_ctrl[SYNC_RST_LSB +: 2] != 2'h0) && rs_fall;
      ctr_rst.b_rst <= ((sync_ctrl[SYNC_RST_LSB +: 2] != 2'h0) && rs_fall) ||
                       (pump_hiz && (manual_hold || auto_hold) &&
                        !next_hiz());
    end
  end

  // Per-pin output multiplexers.
  function automatic logic pin_mux(input logic [5:0] sel);
    unique case (sel)
      MUX_DLD: pin_mux = digital_lock_indicator;
      MUX_CSRC: pin_mux = digital_lock_indicator;
      MUX_CMP_HI: pin_mux = cmp_level;
      MUX_CMP_LO: pin_mux = !cmp_level;
      default: pin_mux = 1'b0;
    endcase
  endfunction

  // Status pin outputs, all registered.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lock_detect_pin <= 1'b0;
      ldpin_src_on <= 1'b0;
      status_pin <= 1'b0;
      reference_monitor_pin <= 1'b0;
    end else begin
      ldpin_src_on <= (ldpin_ctrl[5:0] == MUX_CSRC) &&
                      digital_lock_indicator;
      lock_detect_pin <= (ldpin_ctrl[5:0] == MUX_CSRC) ?
                         (charge_cnt >= 16'(CHARGE_CYC)) :
                         pin_mux(ldpin_ctrl[5:0]);
      status_pin <= pin_mux(pfd_ctrl[STAT_SEL_LSB +: 6]);
      reference_monitor_pin <= pin_mux({1'b0, mon_ctrl[4:0]});
    end
  end

  // Checks.
  lock_needs_count_a:
    assert property (@(posedge clk) disable iff (rst)
    $rose(digital_lock_indicator) |-> $past(pfd_edge.valid))
    else $error("Lock rose without a detector cycle.");
  unlock_on_miss_a:
    assert property (@(posedge clk) disable iff (rst)
    digital_lock_indicator && pfd_edge.valid && pfd_edge.diff > unlock_thr
    |=> !digital_lock_indicator)
    else $error("Lock kept after out-of-window cycle.");
  hold_hiz_a:
    assert property (@(posedge clk) disable iff (rst)
    manual_hold |-> pump_hiz)
    else $error("Pump driven during holdover.");
  fall_enter_a:
    assert property (@(posedge clk) disable iff (rst)
    hold_enabled && hold_ctrl[HOLD_EXT_BIT] && rs_fall |=> pump_hiz)
    else $error("Falling edge did not enter holdover.");
  no_ref_hold_a:
    assert property (@(posedge clk) disable iff (rst)
    manual_hold && !ref_edge && hold_enabled && hold_ctrl[HOLD_EXT_BIT]
    |=> manual_hold)
    else $error("Holdover left without reference edge.");
  pin_rst_off_a:
    assert property (@(posedge clk) disable iff (rst)
    sync_ctrl[7:6] == 2'h0 && !pump_hiz |=> !ctr_rst.r_rst)
    else $error("Counter reset while pin reset disabled.");
  charge_restart_a:
    assert property (@(posedge clk) disable iff (rst)
    !digital_lock_indicator |=> charge_cnt == 16'h0000)
    else $error("Charge not restarted on lock loss.");
  no_enable_a:
    assert property (@(posedge clk) disable iff (rst)
    !hold_enabled |=> !manual_hold && !auto_hold)
    else $error("Holdover active while disabled.");
  lock_cov: cover property (@(posedge clk) $rose(digital_lock_indicator));
  hold_cov: cover property (@(posedge clk) $fell(manual_hold));
  auto_cov: cover property (@(posedge clk) $rose(auto_hold));

endmodule

// [bench/plh_pfd_model.sv]
// Stand-in for the detector side: edge-difference and reference strobes.
module plh_pfd_model
  import plh_pkg::*;
(
  // Clock.
  input wire logic clk,
  // Detector strobes toward the block.
  output plh_edge_type pfd_edge,
  output logic ref_edge
);
  timeunit 1ns;
  timeprecision 1ps;

  // Quiet strobes until the bench starts sending cycles.
  initial begin
    pfd_edge = '0;
    ref_edge = 1'b0;
  end

  // One detector cycle; the task ends with one idle clock, so callers send them back to back.
  task automatic send(input logic [7:0] d, input logic r);
    @(posedge clk);
    pfd_edge <= {1'b1, d};
    ref_edge <= r;
    @(posedge clk);
    // The idle difference is inverted so a stale value is never trusted.
    pfd_edge <= {1'b0, ~d};
    ref_edge <= 1'b0;
  endtask
endmodule

// [bench/pll_lock_detect_holdover_bench.sv]
// Self-checking bench: APB host, resync pin and detector model.
module pll_lock_detect_holdover_bench;
  import plh_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  plh_edge_type pfd_edge;
  logic ref_edge;
  logic resync_n = 1'b1;
  logic ldpin_cmp = 1'b1;
  logic [2:0] r_delay_sel;
  logic [2:0] n_delay_sel;
  plh_ctr_rst_type ctr_rst;
  logic pump_hiz;
  logic lock_detect_pin;
  logic ldpin_src_on;
  logic status_pin;
  logic reference_monitor_pin;
  int mismatches = 0;
  int total_checks = 0;
  logic [31:0] q;
  logic e;
  plh_ctr_rst_type c;

  // The 200 MHz clock.
  always #2.5 clk = ~clk;

  plh_top DUT (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pfd_edge(pfd_edge),
    .ref_edge(ref_edge), .resync_n(resync_n), .ldpin_cmp(ldpin_cmp),
    .r_delay_sel(r_delay_sel), .n_delay_sel(n_delay_sel),
    .ctr_rst(ctr_rst), .pump_hiz(pump_hiz),
    .lock_detect_pin(lock_detect_pin), .ldpin_src_on(ldpin_src_on),
    .status_pin(status_pin),
    .reference_monitor_pin(reference_monitor_pin));

  plh_pfd_model pfd (.clk(clk), .pfd_edge(pfd_edge), .ref_edge(ref_edge));

  // Compares one value and counts the result.
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    total_checks++;
    if (s !== x) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, x, s);
    end
  endtask

  // One APB transfer; the request holds until pready is seen at an edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Ready is sampled at rising edges; the answer is taken at that edge.
    repeat (50) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (pready !== 1'b1) mismatches++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Drives the resync pin just after a rising edge.
  task automatic pin(input logic v);
    @(posedge clk);
    resync_n <= v;
  endtask

  // Lets a few settled cycles pass.
  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Captures the first counter reset strobe within a short span.
  task automatic catch_rst();
    c = '0;
    repeat (10) begin
      @(negedge clk);
      if (ctr_rst !== 3'b000) begin
        c = ctr_rst;
        break;
      end
    end
  endtask

  // Sends n detector cycles with the given difference.
  task automatic run(input int n, input logic [7:0] d);
    repeat (n) pfd.send(d, 1'b0);
    settle(3);
  endtask

  // Prints counts and the verdict, then stops.
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Cuts a hung run short.
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    end_of_test();
  end

  // Main sequence.
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, OFS_SYNC_CTRL, 32'h0);
    chk("sync_ctrl", q, {24'h0, RST_SYNC_CTRL});
    apb(1'b0, 8'hF0, 32'h0);
    chk("slverr", {31'h0, e}, 32'h1);
    pin(1'b0);
    catch_rst();
    chk("no_pin_rst", {29'h0, c}, 32'h0);
    pin(1'b1);
    apb(1'b1, OFS_SYNC_CTRL, 32'hEB);
    settle(2);
    chk("r_dly", {29'h0, r_delay_sel}, 32'h3);
    chk("n_dly", {29'h0, n_delay_sel}, 32'h5);
    pin(1'b0);
    catch_rst();
    chk("pin_rst", {29'h0, c}, 32'h7);
    catch_rst();
    chk("one_rst", {29'h0, c}, 32'h0);
    chk("no_hold", {31'h0, pump_hiz}, 32'h0);
    pin(1'b1);
    apb(1'b1, OFS_SYNC_CTRL, 32'h0);
    // Narrow window: lock 2, unlock 4; difference 3 never counts.
    apb(1'b1, OFS_LOCK_CTRL, 32'h10);
    apb(1'b1, OFS_LDPIN_CTRL, {26'h0, MUX_DLD});
    run(5, 8'h03);
    chk("narrow", {31'h0, lock_detect_pin}, 32'h0);
    apb(1'b1, OFS_LOCK_CTRL, 32'h0);
    run(4, 8'h02);
    run(1, 8'h08);
    run(4, 8'h02);
    chk("restart", {31'h0, lock_detect_pin}, 32'h0);
    run(1, 8'h02);
    chk("lock5", {31'h0, lock_detect_pin}, 32'h1);
    run(1, 8'h0C);
    chk("hyst", {31'h0, lock_detect_pin}, 32'h1);
    // Route the indicator and comparator to the other pins.
    apb(1'b1, OFS_PFD_CTRL, {24'h0, MUX_DLD, 2'b00});
    apb(1'b1, OFS_MON_CTRL, {26'h0, MUX_CMP_LO});
    settle(2);
    chk("status", {31'h0, status_pin}, 32'h1);
    chk("mon_lo", {31'h0, reference_monitor_pin}, 32'h0);
    apb(1'b1, OFS_MON_CTRL, {26'h0, MUX_CMP_HI});
    settle(2);
    chk("mon_hi", {31'h0, reference_monitor_pin}, 32'h1);
    apb(1'b1, OFS_LDPIN_CTRL, {26'h0, MUX_CSRC});
    settle(2);
    chk("src_on", {31'h0, ldpin_src_on}, 32'h1);
    settle(CHARGE_CYC);
    chk("charged", {31'h0, lock_detect_pin}, 32'h1);
    run(1, 8'h28);
    chk("unlock", {31'h0, status_pin}, 32'h0);
    chk("src_off", {31'h0, ldpin_src_on}, 32'h0);
    chk("dumped", {31'h0, lock_detect_pin}, 32'h0);
    // Manual holdover, pin reset left off.
    apb(1'b1, OFS_HOLD_CTRL, 32'h7);
    pin(1'b0);
    settle(6);
    chk("hiz_in", {31'h0, pump_hiz}, 32'h1);
    pin(1'b1);
    pfd.send(8'h02, 1'b0);
    settle(6);
    chk("hiz_hold", {31'h0, pump_hiz}, 32'h1);
    pfd.send(8'h02, 1'b1);
    catch_rst();
    chk("b_rst", {29'h0, c}, 32'h1);
    settle(2);
    chk("hiz_out", {31'h0, pump_hiz}, 32'h0);
    // Holdover is switched off again, as after reset.
    apb(1'b1, OFS_HOLD_CTRL, 32'h0);
    apb(1'b0, OFS_HOLD_CTRL, 32'h0);
    chk("hold_off", q, 32'h0);
    end_of_test();
  end
endmodule
